/* File: hdl/uq_defs.vh */
// Constants of the serial port with LIN, handshake and smart card quirks.
// Assumes inclusion by bare name from the design files of this block.
// Functional notes
// - In smart card mode every read of the error count register is zero.
// - As LIN master the identifier is never taken from the DMA buffer.
// - Writing the identifier register starts the frame once DMA is ready.
// - The identifier flag is raised only on a received header.
// - With the LIN DMA mode bit set a LIN transfer never starts.
// - In handshake mode RTS stays low even when the DMA buffer is full.
// - Writing one to the force-high command drives RTS high.
// - Writing one to the force-low command drives RTS low again.
// - In protocol T1 the receiver dies after any send until recovery.
`ifndef UQ_DEFS_VH
`define UQ_DEFS_VH
// ********************
// Register offsets
// ********************
`define UQ_ADR_CTRL 8'h00
`define UQ_ADR_MODE 8'h04
`define UQ_ADR_LINMODE 8'h08
`define UQ_ADR_LIN_IDENTIFIER 8'h0C
`define UQ_ADR_ERRCNT 8'h10
`define UQ_ADR_STATUS 8'h14
`define UQ_ADR_IRQCLR 8'h18
`define UQ_ADR_IRQEN 8'h1C
`define UQ_ADR_RXDATA 8'h20
`define UQ_ADR_BAUD 8'h24
// ********************
// Fields and codes
// ********************
`define UQ_CTRL_RXRST 0
`define UQ_CTRL_RTSHI 1
`define UQ_CTRL_RTSLO 2
`define UQ_LINMODE_DMA 0
`define UQ_ST_RXRDY 0
`define UQ_ST_TXDONE 1
`define UQ_ST_LIN_IDENTIFIER 2
`define UQ_ST_FERR 3
`define UQ_MODE_NORMAL 3'h0
`define UQ_MODE_HSHAKE 3'h1
`define UQ_MODE_ISO_T0 3'h2
`define UQ_MODE_ISO_T1 3'h3
`define UQ_MODE_LIN_MST 3'h4
`define UQ_MODE_LIN_SLV 3'h5
`define UQ_LIN_SYNC 8'h55
// ********************
// Reset values
// ********************
`define UQ_RST_MODE 3'h0
`define UQ_RST_BAUD 16'h0007
`endif

/* File: hdl/uq_tx.v */
// Byte transmitter: one start bit, eight data bits LSB first, one stop.
// Assumes the divisor is stable while a byte is on the line.
`timescale 1ns/1ps
`default_nettype none
module uq_tx
(
   input wire clk_i,
   input wire rst_i,
   input wire [15:0] div_i,
   input wire start_i,
   input wire [7:0] data_i,
   output reg tx_o,
   output reg busy_o,
   output reg done_o
);
   reg [15:0] cnt;
   reg [3:0] bitn;
   reg [8:0] sh;

   // A bit lasts div_i + 1 clock cycles.
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tx_o <= 1'b1;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         cnt <= 16'h0000;
         bitn <= 4'h0;
         sh <= 9'h1FF;
      end
      else
      begin
         done_o <= 1'b0;
         if (!busy_o)
         begin
            if (start_i)
            begin
               tx_o <= 1'b0;
               busy_o <= 1'b1;
               sh <= {1'b1, data_i};
               cnt <= div_i;
               bitn <= 4'h0;
            end
         end
         else if (cnt != 16'h0000)
            cnt <= cnt - 16'h0001;
         else
         begin
            cnt <= div_i;
            if (bitn == 4'h9)
            begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end
            else
            begin
               tx_o <= sh[0];
               sh <= {1'b1, sh[8:1]};
               bitn <= bitn + 4'h1;
            end
         end
      end
   end
endmodule // uq_tx
`default_nettype wire

/* File: hdl/uq_rx.v */
// Byte receiver sampling each bit in its middle.
// Assumes rx_i is already synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module uq_rx
(
   input wire clk_i,
   input wire rst_i,
   input wire en_i,
   input wire [15:0] div_i,
   input wire rx_i,
   output reg [7:0] data_o,
   output reg valid_o,
   output reg ferr_o
);
   reg busy;
   reg [15:0] cnt;
   reg [3:0] bitn;

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         busy <= 1'b0;
         cnt <= 16'h0000;
         bitn <= 4'h0;
         data_o <= 8'h00;
         valid_o <= 1'b0;
         ferr_o <= 1'b0;
      end
      else
      begin
         valid_o <= 1'b0;
         ferr_o <= 1'b0;
         if (!en_i)
            busy <= 1'b0;
         else if (!busy)
         begin
            if (!rx_i)
            begin
               busy <= 1'b1;
               cnt <= {1'b0, div_i[15:1]};
               bitn <= 4'h0;
            end
         end
         else if (cnt != 16'h0000)
            cnt <= cnt - 16'h0001;
         else
         begin
            cnt <= div_i;
            bitn <= bitn + 4'h1;
            // A start bit that is gone by mid-bit was a glitch.
            if (bitn == 4'h0)
               busy <= rx_i ? 1'b0 : 1'b1;
            else if (bitn == 4'h9)
            begin
               busy <= 1'b0;
               valid_o <= 1'b1;
               ferr_o <= ~rx_i;
            end
            else
               data_o <= {rx_i, data_o[7:1]};
         end
      end
   end
endmodule // uq_rx
`default_nettype wire

/* File: hdl/uq_top.v */
// Serial port core with LIN master and slave, handshake and smart card
// modes, a classic Wishbone register slave and a byte-wide DMA port.
// Assumes serial and DMA inputs are synchronous to clk_i.
//
// The implementer's own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "uq_defs.vh"
module uq_top
(
   input wire clk_i,
   input wire rst_i,
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [3:0] wb_sel_i,
   input wire wb_we_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire dma_tx_rdy_i,
   input wire dma_tx_valid_i,
   input wire [7:0] dma_tx_data_i,
   output reg dma_tx_ack_o,
   output reg [7:0] dma_rx_data_o,
   output reg dma_rx_valid_o,
   input wire rxd_i,
   output reg txd_o,
   output reg rts_o,
   output reg irq_o
);
   localparam S_IDLE = 2'd0;
   localparam S_SYNC = 2'd1;
   localparam S_ID = 2'd2;
   localparam S_DATA = 2'd3;

   reg [2:0] mode;
   reg lin_dma_mode_bit;
   reg [7:0] lin_identifier;
   reg lin_pend;
   reg [7:0] err_cnt;
   reg [3:0] status;
   reg [3:0] irq_en;
   reg [15:0] baud;
   reg [1:0] state;
   reg [1:0] next_state;
   reg rx_dead;
   reg [1:0] recover;
   reg last_sync;
   reg tx_start;
   reg [7:0] tx_byte;
   reg take_dma;
   reg [31:0] rd_data;
   reg [3:0] next_status;
   wire tx_line;
   wire tx_busy;
   wire tx_done;
   wire [7:0] rx_byte;
   wire rx_valid;
   wire rx_ferr;
   wire acc;
   wire wr;
   wire wr_lo;
   wire is_lin;
   wire is_iso;
   wire rx_srst;
   wire cmd_rts_hi;
   wire cmd_rts_lo;
   wire lin_id_evt;

   // ********************
   // Bus decode
   // ********************
   // A write takes effect on the edge where the master sees ack high.
   assign acc = wb_cyc_i & wb_stb_i;
   assign wr = acc & wb_we_i & wb_ack_o;
   assign wr_lo = wr & wb_sel_i[0];
   assign is_lin = (mode == `UQ_MODE_LIN_MST) | (mode == `UQ_MODE_LIN_SLV);
   assign is_iso = (mode == `UQ_MODE_ISO_T0) | (mode == `UQ_MODE_ISO_T1);
   // Command bits only act when written with one.
   assign rx_srst = wr_lo & (wb_adr_i == `UQ_ADR_CTRL) &
                    wb_dat_i[`UQ_CTRL_RXRST];
   assign cmd_rts_hi = wr_lo & (wb_adr_i == `UQ_ADR_CTRL) &
                       wb_dat_i[`UQ_CTRL_RTSHI];
   assign cmd_rts_lo = wr_lo & (wb_adr_i == `UQ_ADR_CTRL) &
                       wb_dat_i[`UQ_CTRL_RTSLO];
   // Only a header arriving in slave mode names an identifier.
   assign lin_id_evt = rx_valid & (mode == `UQ_MODE_LIN_SLV) &
                       last_sync & ~rx_ferr;

   uq_tx uq_tx_inst
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .div_i(baud),
      .start_i(tx_start),
      .data_i(tx_byte),
      .tx_o(tx_line),
      .busy_o(tx_busy),
      .done_o(tx_done)
   );

   uq_rx uq_rx_inst
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .en_i(~rx_dead & ~rx_srst),
      .div_i(baud),
      .rx_i(rxd_i),
      .data_o(rx_byte),
      .valid_o(rx_valid),
      .ferr_o(rx_ferr)
   );

   // ********************
   // Transmit sequencing
   // ********************
   always @*
   begin
      next_state = state;
      tx_start = 1'b0;
      tx_byte = dma_tx_data_i;
      take_dma = 1'b0;
      case (state)
         S_IDLE:
         begin
            if (mode == `UQ_MODE_LIN_MST)
            begin
               // The identifier never comes from the DMA buffer, and the
               // DMA mode bit keeps the frame from ever starting.
               if (lin_pend & dma_tx_rdy_i & ~lin_dma_mode_bit &
                   ~tx_busy)
               begin
                  tx_start = 1'b1;
                  tx_byte = `UQ_LIN_SYNC;
                  next_state = S_SYNC;
               end
            end
            else if ((mode != `UQ_MODE_LIN_SLV) & dma_tx_rdy_i &
                     dma_tx_valid_i & ~tx_busy & ~dma_tx_ack_o)
            begin
               tx_start = 1'b1;
               take_dma = 1'b1;
            end
         end
         S_SYNC:
         begin
            if (tx_done)
            begin
               tx_start = 1'b1;
               tx_byte = lin_identifier;
               next_state = S_ID;
            end
         end
         S_ID:
         begin
            if (tx_done)
               next_state = S_DATA;
         end
         S_DATA:
         begin
            if (!tx_busy & !tx_done)
            begin
               if (!dma_tx_rdy_i)
                  next_state = S_IDLE;
               else if (dma_tx_valid_i & ~dma_tx_ack_o)
               begin
                  tx_start = 1'b1;
                  take_dma = 1'b1;
               end
            end
         end
         default:
            next_state = S_IDLE;
      endcase
   end

   // ********************
   // Status and interrupt
   // ********************
   // An event in the cycle of its clear keeps the bit set.
   always @*
   begin
      next_status = status;
      if (wr_lo & (wb_adr_i == `UQ_ADR_IRQCLR))
         next_status = status & ~wb_dat_i[3:0];
      if (rx_valid)
         next_status[`UQ_ST_RXRDY] = 1'b1;
      if (tx_done)
         next_status[`UQ_ST_TXDONE] = 1'b1;
      if (lin_id_evt)
         next_status[`UQ_ST_LIN_IDENTIFIER] = 1'b1;
      if (rx_valid & rx_ferr)
         next_status[`UQ_ST_FERR] = 1'b1;
   end

   // ********************
   // Read mux
   // ********************
   always @*
   begin
      rd_data = 32'h00000000;
      case (wb_adr_i)
         `UQ_ADR_MODE:
            rd_data[2:0] = mode;
         `UQ_ADR_LINMODE:
            rd_data[`UQ_LINMODE_DMA] = lin_dma_mode_bit;
         `UQ_ADR_LIN_IDENTIFIER:
            rd_data[7:0] = lin_identifier;
         `UQ_ADR_ERRCNT:
            rd_data[7:0] = is_iso ? 8'h00 : err_cnt;
         `UQ_ADR_STATUS:
            rd_data[3:0] = status;
         `UQ_ADR_IRQEN:
            rd_data[3:0] = irq_en;
         `UQ_ADR_RXDATA:
            rd_data[7:0] = dma_rx_data_o;
         `UQ_ADR_BAUD:
            rd_data[15:0] = baud;
         default:
            rd_data = 32'h00000000;
      endcase
   end

   // ********************
   // Registers
   // ********************
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         mode <= `UQ_RST_MODE;
         lin_dma_mode_bit <= 1'b0;
         lin_identifier <= 8'h00;
         lin_pend <= 1'b0;
         err_cnt <= 8'h00;
         status <= 4'h0;
         irq_en <= 4'h0;
         baud <= `UQ_RST_BAUD;
         state <= S_IDLE;
         rx_dead <= 1'b0;
         recover <= 2'b00;
         last_sync <= 1'b0;
         dma_tx_ack_o <= 1'b0;
         dma_rx_data_o <= 8'h00;
         dma_rx_valid_o <= 1'b0;
         txd_o <= 1'b1;
         rts_o <= 1'b0;
         irq_o <= 1'b0;
      end
      else
      begin
         wb_ack_o <= acc & ~wb_ack_o;
         if (acc & ~wb_ack_o)
            wb_dat_o <= rd_data;
         if (wr_lo & (wb_adr_i == `UQ_ADR_MODE))
            mode <= wb_dat_i[2:0];
         if (wr_lo & (wb_adr_i == `UQ_ADR_LINMODE))
            lin_dma_mode_bit <= wb_dat_i[`UQ_LINMODE_DMA];
         if (wr_lo & (wb_adr_i == `UQ_ADR_IRQEN))
            irq_en <= wb_dat_i[3:0];
         if (wr_lo & (wb_adr_i == `UQ_ADR_BAUD))
            baud[7:0] <= wb_dat_i[7:0];
         if (wr & wb_sel_i[1] & (wb_adr_i == `UQ_ADR_BAUD))
            baud[15:8] <= wb_dat_i[15:8];
         // The identifier write arms the frame; the DMA start gates it.
         if (wr_lo & (wb_adr_i == `UQ_ADR_LIN_IDENTIFIER))
         begin
            lin_identifier <= wb_dat_i[7:0];
            lin_pend <= 1'b1;
         end
         else if (state == S_IDLE & next_state == S_SYNC)
            lin_pend <= 1'b0;
         else if (lin_id_evt)
            lin_identifier <= rx_byte;
         state <= next_state;
         txd_o <= tx_line;
         dma_tx_ack_o <= take_dma;
         dma_rx_valid_o <= rx_valid;
         if (rx_valid)
         begin
            dma_rx_data_o <= rx_byte;
            last_sync <= (rx_byte == `UQ_LIN_SYNC) & ~lin_id_evt;
         end
         if (rx_valid & rx_ferr & (err_cnt != 8'hFF))
            err_cnt <= err_cnt + 8'h01;
         status <= next_status;
         irq_o <= |(next_status & irq_en);
         // Hardware handshake never raises RTS on a full DMA buffer; it
         // moves only on the two commands, force-high winning a tie.
         if (cmd_rts_hi)
            rts_o <= 1'b1;
         else if (cmd_rts_lo)
            rts_o <= 1'b0;
         // T1 receive stays dead after a send until a receiver reset,
         // then a mode write, then a control write; a send restarts it.
         if ((mode == `UQ_MODE_ISO_T1) & tx_done)
         begin
            rx_dead <= 1'b1;
            recover <= 2'b00;
         end
         else if (rx_srst & (recover == 2'b00))
            recover <= 2'b01;
         else if ((recover == 2'b01) & wr_lo &
                  (wb_adr_i == `UQ_ADR_MODE))
            recover <= 2'b10;
         else if ((recover == 2'b10) & wr_lo &
                  (wb_adr_i == `UQ_ADR_CTRL))
         begin
            recover <= 2'b00;
            rx_dead <= 1'b0;
         end
      end
   end
endmodule // uq_top
`default_nettype wire

/* File: test/uq_sva.sv */
// Checker of bus, DMA and RTS timing at the serial port core's ports.
// Assumes it is bound to uq_top and that rst_i is synchronous.
`timescale 1ns/1ps
`default_nettype none
`include "uq_defs.vh"
module uq_sva
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic dma_tx_rdy_i,
   input wire logic dma_tx_valid_i,
   input wire logic dma_tx_ack_o,
   input wire logic txd_o,
   input wire logic rts_o,
   input wire logic irq_o
);
   wire logic ctrl_wr = wb_ack_o && wb_we_i && wb_sel_i[0]
      && wb_adr_i == `UQ_ADR_CTRL;
   // Only a command write with an RTS bit set may move the RTS pin.
   wire logic ctrl_hit = ctrl_wr && (wb_dat_i[1] || wb_dat_i[2]);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ********************
   // Assertions
   // ********************
   a_ack_next:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack one cycle after a request");
   a_ctrl_zero:
      assert property (wb_ack_o && !wb_we_i && wb_adr_i == `UQ_ADR_CTRL
         |-> wb_dat_o == 32'h0) else $error("command register not zero");
   a_rts_high:
      assert property (ctrl_wr && wb_dat_i[1] |-> ##[1:2] rts_o)
      else $error("rts not forced high");
   a_rts_low:
      assert property (ctrl_wr && wb_dat_i[2] && !wb_dat_i[1]
         |-> ##[1:2] !rts_o) else $error("rts not forced low");
   a_rts_cause:
      assert property ($changed(rts_o) |-> $past(ctrl_hit)
         || $past(ctrl_hit, 2)) else $error("rts moved on its own");
   a_dma_pulse:
      assert property (dma_tx_ack_o |=> !dma_tx_ack_o)
      else $error("dma ack longer than one cycle");
   a_dma_cause:
      assert property (dma_tx_ack_o |-> $past(dma_tx_rdy_i)
         && $past(dma_tx_valid_i)) else $error("dma ack without request");
   a_reset_idle:
      assert property (disable iff (1'h0) rst_i |=> txd_o && !rts_o
         && !irq_o && !wb_ack_o) else $error("outputs not idle in reset");
endmodule // uq_sva
bind uq_top uq_sva uq_sva_inst (.clk_i(clk_i), .rst_i(rst_i),
   .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
   .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dma_tx_rdy_i(dma_tx_rdy_i),
   .dma_tx_valid_i(dma_tx_valid_i), .dma_tx_ack_o(dma_tx_ack_o),
   .txd_o(txd_o), .rts_o(rts_o), .irq_o(irq_o));
`default_nettype wire

/* File: test/uq_peer.sv */
// Serial far side: drives frames onto rxd and decodes bytes from txd.
// Assumes BIT clock cycles per bit and an idle high line.
`timescale 1ns/1ps
`default_nettype none
module uq_peer
#(
   parameter int BIT = 8
)
(
   input wire logic clk_i,
   input wire logic txd_i,
   output logic rxd_o
);
   logic [7:0] got [$];
   logic [7:0] v;
   integer i;
   initial rxd_o = 1'h1;
   task automatic send(input logic [7:0] b, input logic stp);
      logic [9:0] f;
      integer k;
      begin
         f = {stp, b, 1'h0};
         for (k = 0; k < 10; k++)
         begin
            @(posedge clk_i);
            rxd_o <= f[k];
            repeat (BIT - 1) @(posedge clk_i);
         end
         @(posedge clk_i);
         rxd_o <= 1'h1;
      end
   endtask
   // Sampling on the falling edge keeps clear of the core's own updates.
   initial
   begin
      forever
      begin
         @(negedge clk_i);
         if (txd_i === 1'h0)
         begin
            repeat (BIT / 2) @(negedge clk_i);
            for (i = 0; i < 8; i++)
            begin
               repeat (BIT) @(negedge clk_i);
               v[i] = txd_i;
            end
            got.push_back(v);
            repeat (BIT) @(negedge clk_i);
         end
      end
   end
endmodule // uq_peer
`default_nettype wire

/* File: test/test_usart_lin_handshake_quirks.sv */
// Self-checking bench of the serial port core with a serial peer model.
// Assumes uq_top, its checker and uq_peer are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "uq_defs.vh"
module test_usart_lin_handshake_quirks;
   localparam int BIT = `UQ_RST_BAUD + 1;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [3:0] wb_sel_i = 4'hF;
   logic wb_we_i = 1'h0;
   logic wb_cyc_i = 1'h0;
   logic wb_stb_i = 1'h0;
   logic dma_tx_rdy_i = 1'h0;
   logic dma_tx_valid_i = 1'h0;
   logic [7:0] dma_tx_data_i = 8'h00;
   logic [31:0] wb_dat_o, q;
   logic [31:0] seed = 32'hF49CC53D;
   logic [7:0] dma_rx_data_o, rxb, id;
   logic wb_ack_o, dma_tx_ack_o, dma_rx_valid_o, rxd_i, txd_o, rts_o, irq_o;
   logic [7:0] dbuf [0:15];
   logic [7:0] ex [$];
   integer failures = 0, comparisons = 0, dptr = 0, dn = 0, rxn = 0, n0;
   uq_top uq_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .dma_tx_rdy_i(dma_tx_rdy_i),
      .dma_tx_valid_i(dma_tx_valid_i), .dma_tx_data_i(dma_tx_data_i),
      .dma_tx_ack_o(dma_tx_ack_o), .dma_rx_data_o(dma_rx_data_o),
      .dma_rx_valid_o(dma_rx_valid_o), .rxd_i(rxd_i), .txd_o(txd_o),
      .rts_o(rts_o), .irq_o(irq_o));
   uq_peer #(.BIT(BIT)) uq_peer_inst (.clk_i(clk_i), .txd_i(txd_o),
      .rxd_o(rxd_i));
   always #50 clk_i = ~clk_i;
   // Idle DMA data toggles so a byte taken out of turn shows up.
   always @(posedge clk_i)
   begin
      if (dma_tx_ack_o === 1'h1)
         dptr = dptr + 1;
      dma_tx_valid_i <= dptr < dn;
      dma_tx_data_i <= (dptr < dn) ? dbuf[dptr] : ~dma_tx_data_i;
      if (dma_rx_valid_o === 1'h1)
      begin
         rxn <= rxn + 1;
         rxb <= dma_rx_data_o;
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      begin
         x = s ^ (s << 13);
         x = x ^ (x >> 17);
         xs = x ^ (x << 5);
      end
   endfunction
   task chk(input logic [31:0] g, input logic [31:0] e);
      begin
         comparisons = comparisons + 1;
         if (g !== e)
         begin
            failures = failures + 1;
            $display("BAD %0t got %h want %h", $time, g, e);
         end
      end
   endtask
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      begin
         @(posedge clk_i);
         wb_cyc_i <= 1'h1;
         wb_stb_i <= 1'h1;
         wb_we_i <= we;
         wb_adr_i <= a;
         wb_dat_i <= d;
         // Ack and read data are taken at the rising edge where ack is high.
         @(posedge clk_i);
         while (wb_ack_o !== 1'h1)
            @(posedge clk_i);
         q = wb_dat_o;
         wb_cyc_i <= 1'h0;
         wb_stb_i <= 1'h0;
         repeat (2) @(negedge clk_i);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'h1, a, d);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      begin
         wb(1'h0, a, 32'h0);
         chk(q, e);
      end
   endtask
   task rdy(input logic v);
      begin
         @(posedge clk_i);
         dma_tx_rdy_i <= v;
      end
   endtask
   task push(input integer n);
      integer k;
      begin
         for (k = 0; k < n; k++)
         begin
            @(posedge clk_i);
            seed = xs(seed);
            dbuf[dn] <= seed[7:0];
            dn <= dn + 1;
            ex.push_back(seed[7:0]);
         end
      end
   endtask
   task gotn(input integer n);
      while (uq_peer_inst.got.size() < n)
         @(negedge clk_i);
   endtask
   task cmp_tx(input integer off);
      integer k;
      begin
         for (k = 0; k < ex.size(); k++)
            chk(uq_peer_inst.got[off + k], ex[k]);
         ex.delete();
         uq_peer_inst.got.delete();
      end
   endtask
   task results;
      begin
         $display("comparisons %0d failures %0d", comparisons, failures);
         if (failures == 0 && comparisons > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   initial
   begin
      repeat (20000) @(posedge clk_i);
      failures = failures + 1;
      results;
   end
   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'h0;
      rd(`UQ_ADR_MODE, {29'h0, `UQ_RST_MODE});
      rd(`UQ_ADR_BAUD, {16'h0, `UQ_RST_BAUD});
      rd(`UQ_ADR_IRQEN, 32'h0);
      rd(`UQ_ADR_CTRL, 32'h0);
      wr(8'h30, 32'hFF);
      rd(8'h30, 32'h0);
      wr(`UQ_ADR_BAUD, 32'h0000ABCD);
      rd(`UQ_ADR_BAUD, 32'h0000ABCD);
      wr(`UQ_ADR_BAUD, {16'h0, `UQ_RST_BAUD});
      $display("registers done");
      wr(`UQ_ADR_CTRL, 32'h2);
      chk(rts_o, 1'h1);
      wr(`UQ_ADR_CTRL, 32'h0);
      chk(rts_o, 1'h1);
      wr(`UQ_ADR_CTRL, 32'h4);
      chk(rts_o, 1'h0);
      wr(`UQ_ADR_MODE, `UQ_MODE_HSHAKE);
      repeat (2)
      begin
         seed = xs(seed);
         uq_peer_inst.send(seed[7:0], 1'h1);
         rd(`UQ_ADR_RXDATA, seed[7:0]);
         chk(rts_o, 1'h0);
      end
      $display("rts done");
      wr(`UQ_ADR_MODE, `UQ_MODE_NORMAL);
      wr(`UQ_ADR_IRQEN, 32'h2);
      push(2);
      rdy(1'h1);
      gotn(2);
      rdy(1'h0);
      cmp_tx(0);
      repeat (20) @(negedge clk_i);
      chk(irq_o, 1'h1);
      wr(`UQ_ADR_IRQEN, 32'h0);
      chk(irq_o, 1'h0);
      wr(`UQ_ADR_IRQEN, 32'h2);
      chk(irq_o, 1'h1);
      wr(`UQ_ADR_IRQCLR, 32'h2);
      chk(irq_o, 1'h0);
      $display("dma and irq done");
      wr(`UQ_ADR_MODE, `UQ_MODE_LIN_MST);
      wr(`UQ_ADR_LINMODE, 32'h0);
      push(2);
      rdy(1'h1);
      n0 = dptr;
      repeat (100) @(negedge clk_i);
      chk(dptr, n0);
      seed = xs(seed);
      id = seed[7:0];
      wr(`UQ_ADR_LIN_IDENTIFIER, id);
      gotn(4);
      rdy(1'h0);
      chk(uq_peer_inst.got[0], `UQ_LIN_SYNC);
      chk(uq_peer_inst.got[1], id);
      cmp_tx(2);
      wb(1'h0, `UQ_ADR_STATUS, 32'h0);
      chk(q[`UQ_ST_LIN_IDENTIFIER], 1'h0);
      wr(`UQ_ADR_MODE, `UQ_MODE_LIN_SLV);
      id = ~id;
      uq_peer_inst.send(`UQ_LIN_SYNC, 1'h1);
      uq_peer_inst.send(id, 1'h1);
      wb(1'h0, `UQ_ADR_STATUS, 32'h0);
      chk(q[`UQ_ST_LIN_IDENTIFIER], 1'h1);
      rd(`UQ_ADR_LIN_IDENTIFIER, id);
      $display("lin done");
      wr(`UQ_ADR_MODE, `UQ_MODE_NORMAL);
      uq_peer_inst.send(8'h00, 1'h0);
      rd(`UQ_ADR_ERRCNT, 32'h1);
      wb(1'h0, `UQ_ADR_STATUS, 32'h0);
      chk(q[`UQ_ST_FERR], 1'h1);
      wr(`UQ_ADR_MODE, `UQ_MODE_ISO_T0);
      rd(`UQ_ADR_ERRCNT, 32'h0);
      wr(`UQ_ADR_MODE, `UQ_MODE_ISO_T1);
      rd(`UQ_ADR_ERRCNT, 32'h0);
      push(1);
      rdy(1'h1);
      gotn(1);
      rdy(1'h0);
      cmp_tx(0);
      repeat (20) @(negedge clk_i);
      n0 = rxn;
      uq_peer_inst.send(8'hA5, 1'h1);
      repeat (4) @(negedge clk_i);
      chk(rxn, n0);
      wr(`UQ_ADR_CTRL, 32'h1);
      wr(`UQ_ADR_MODE, `UQ_MODE_ISO_T1);
      wr(`UQ_ADR_CTRL, 32'h0);
      seed = xs(seed);
      uq_peer_inst.send(seed[7:0], 1'h1);
      repeat (4) @(negedge clk_i);
      chk(rxn, n0 + 1);
      chk(rxb, seed[7:0]);
      $display("smart card done");
      wr(`UQ_ADR_MODE, `UQ_MODE_LIN_MST);
      wr(`UQ_ADR_LINMODE, 32'h1);
      push(1);
      rdy(1'h1);
      n0 = dptr;
      wr(`UQ_ADR_LIN_IDENTIFIER, id);
      repeat (200) @(negedge clk_i);
      chk(dptr, n0);
      chk(uq_peer_inst.got.size(), 0);
      $display("lin dma mode done");
      results;
   end
endmodule // test_usart_lin_handshake_quirks
`default_nettype wire
